// ---- include/mmrb_pkg.sv ----
package mmrb_pkg;
	// register offsets (byte addresses)
	localparam logic [10:0] OFS_CTRL      = 11'h000;
	localparam logic [10:0] OFS_REQ_HEAD  = 11'h004;
	localparam logic [10:0] OFS_REQ_START = 11'h008;
	localparam logic [10:0] OFS_REQ_COUNT = 11'h00C;
	localparam logic [10:0] OFS_STATUS    = 11'h010;
	localparam logic [10:0] OFS_GAP       = 11'h014;
	localparam logic [10:0] OFS_REPLY     = 11'h018;
	localparam int          DEST_SEL_BIT  = 10;
	// control fields
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_ASCII_BIT = 1;
	localparam int CTRL_EN32_BIT  = 2;
	// status fields
	localparam int ST_BUSY_BIT    = 0;
	localparam int ST_DONE_BIT    = 1;
	localparam int ST_TMO_BIT     = 2;
	localparam int ST_EXC_BIT     = 3;
	localparam int ST_CRC_BIT     = 4;
	localparam int ST_BADOP_BIT   = 5;
	localparam int ST_CODE_LSB    = 8;
	localparam int ST_WORDS_LSB   = 16;
	// opcodes
	localparam logic [7:0] OP_RD_COILS  = 8'h01;
	localparam logic [7:0] OP_RD_INPUTS = 8'h02;
	localparam logic [7:0] OP_RD_HOLD   = 8'h03;
	localparam logic [7:0] OP_RD_INREG  = 8'h04;
	localparam logic [7:0] OP_WR_COIL   = 8'h05;
	localparam logic [7:0] OP_WR_REG    = 8'h06;
	localparam logic [7:0] OP_RD_EXC    = 8'h07;
	localparam logic [7:0] OP_LOOPBACK  = 8'h08;
	localparam logic [7:0] OP_EV_CNT    = 8'h0B;
	localparam logic [7:0] OP_EV_LOG    = 8'h0C;
	localparam logic [7:0] OP_WR_COILS  = 8'h0F;
	localparam logic [7:0] OP_WR_REGS   = 8'h10;
	localparam logic [7:0] OP_WIDE_MASK = 8'h40;
	localparam logic [7:0] OP_EXC_MASK  = 8'h80;
	// frame layout
	localparam logic [15:0] CRC_INIT    = 16'hFFFF;
	localparam logic [15:0] CRC_POLY    = 16'hA001;
	localparam logic [8:0]  LEN_SHORT   = 9'h002;
	localparam logic [8:0]  LEN_FULL    = 9'h006;
	localparam logic [7:0]  PAD_BYTE    = 8'h00;
	// timing
	localparam int CLK_HZ          = 20_000_000;
	localparam int GAP_TIME_US     = 4000;
	localparam int GAP_CYCLES      = GAP_TIME_US * (CLK_HZ / 1_000_000);
	localparam int REPLY_TIME_MS   = 1000;
	localparam int REPLY_CYCLES    = REPLY_TIME_MS * (CLK_HZ / 1000);
	// reset values
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [31:0] RST_DATA = 32'h00000000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEND = 2'b01,
		ST_WAIT = 2'b11,
		ST_RECV = 2'b10
	} mmrb_state_type;
endpackage

// ---- src/mmrb_dest_mem.sv ----
`timescale 1ns/1ps
module mmrb_dest_mem #(
	parameter int AW = 8,
	parameter int DW = 16
) (
	input  wire logic          i_clk,
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_waddr,
	input  wire logic [DW-1:0] i_wdata,
	input  wire logic [AW-1:0] i_raddr,
	output logic      [DW-1:0] o_rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge i_clk)
	begin
		if (i_we)
		begin
			mem[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk)
	begin
		o_rdata <= mem[i_raddr];
	end
endmodule // mmrb_dest_mem

// ---- src/mmrb_top.sv ----
`timescale 1ns/1ps
module mmrb_top
	import mmrb_pkg::*;
#(
	parameter int unsigned GAP_CNT   = mmrb_pkg::GAP_CYCLES,
	parameter int unsigned REPLY_CNT = mmrb_pkg::REPLY_CYCLES,
	parameter int          MEM_AW    = 8
) (
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic [10:0] i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	output logic      [7:0]  o_tx_data,
	output logic             o_tx_valid,
	input  wire logic        i_tx_ready,
	input  wire logic [7:0]  i_rx_data,
	input  wire logic        i_rx_valid,
	output logic             o_busy
);
	import mmrb_pkg::*;

	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int k = 0; k < 8; k++)
		begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic logic op_ok(input logic [7:0] op, input logic ascii, input logic en32);
		logic [7:0] b;
		logic       known;
		b = op & ~OP_WIDE_MASK;
		known = (b == OP_RD_COILS) || (b == OP_RD_INPUTS) || (b == OP_RD_HOLD) || (b == OP_RD_INREG)
			|| (b == OP_WR_COIL) || (b == OP_WR_REG) || (b == OP_RD_EXC) || (b == OP_LOOPBACK)
			|| (b == OP_EV_CNT) || (b == OP_EV_LOG) || (b == OP_WR_COILS) || (b == OP_WR_REGS);
		if (op[6])
		begin
			known = ascii && en32 && ((b == OP_RD_HOLD) || (b == OP_WR_REG) || (b == OP_WR_REGS));
		end
		return known;
	endfunction

	function automatic logic is_bit_read(input logic [7:0] b);
		return (b == OP_RD_COILS) || (b == OP_RD_INPUTS);
	endfunction

	function automatic logic is_reg_read(input logic [7:0] b);
		return (b == OP_RD_HOLD) || (b == OP_RD_INREG);
	endfunction

	mmrb_state_type state_q;
	logic [7:0]  slave_q;
	logic [7:0]  op_q;
	logic [15:0] start_q;
	logic [15:0] count_q;
	logic        ascii_q;
	logic        en32_q;
	logic [31:0] gap_q;
	logic [31:0] reply_q;
	logic        done_q;
	logic        tmo_q;
	logic        exc_q;
	logic        crcerr_q;
	logic        badop_q;
	logic [7:0]  code_q;
	logic [7:0]  wire_op_q;
	logic [8:0]  tx_idx_q;
	logic [15:0] crc_q;
	logic [7:0]  tx_data_q;
	logic        tx_valid_q;
	logic [31:0] timer_q;
	logic [8:0]  rx_idx_q;
	logic [7:0]  nbytes_q;
	logic [7:0]  dcnt_q;
	logic [7:0]  pend_q;
	logic [MEM_AW-1:0] widx_q;
	logic [8:0]  words_q;
	logic        rd_dest_q;
	logic [31:0] reg_rdata_q;

	logic [7:0]        base_op;
	logic [8:0]        tx_len;
	logic              tx_fire;
	logic [8:0]        tx_nidx;
	logic [15:0]       tx_crc_n;
	logic [7:0]        tx_next;
	logic              start_req;
	logic              mem_we;
	logic [15:0]       mem_wdata;
	logic [MEM_AW-1:0] mem_raddr;
	logic [15:0]       mem_rdata;
	logic              stores;
	logic              is_data_byte;
	logic              last_data;

	assign base_op   = op_q & ~OP_WIDE_MASK;
	assign tx_len    = ((base_op == OP_RD_EXC) || (base_op == OP_EV_CNT) || (base_op == OP_EV_LOG))
		? LEN_SHORT : LEN_FULL;
	assign tx_fire   = tx_valid_q && i_tx_ready;
	assign tx_nidx   = tx_idx_q + 9'd1;
	assign tx_crc_n  = crc_upd(crc_q, tx_data_q);
	assign start_req = i_wr && (i_addr == OFS_CTRL) && i_wdata[CTRL_START_BIT] && (state_q == ST_IDLE);
	assign stores    = is_bit_read(base_op) || is_reg_read(base_op);
	assign is_data_byte = (state_q != ST_IDLE) && i_rx_valid && stores && !exc_q
		&& (rx_idx_q >= 9'd3) && (dcnt_q < nbytes_q) && (wire_op_q[7] == 1'b0);
	assign last_data = (dcnt_q + 8'd1) == nbytes_q;
	assign o_tx_data  = tx_data_q;
	assign o_tx_valid = tx_valid_q;
	assign o_busy     = state_q != ST_IDLE;

	always_comb
	begin
		tx_next = PAD_BYTE;
		unique case (tx_nidx)
			9'd1: tx_next = wire_op_q;
			9'd2: tx_next = start_q[15:8];
			9'd3: tx_next = start_q[7:0];
			9'd4: tx_next = count_q[15:8];
			9'd5: tx_next = count_q[7:0];
			default: tx_next = PAD_BYTE;
		endcase
		if (tx_nidx == tx_len)
		begin
			tx_next = tx_crc_n[7:0];
		end
		else if (tx_nidx == tx_len + 9'd1)
		begin
			tx_next = crc_q[15:8];
		end
	end

	// configuration registers
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			slave_q <= RST_BYTE;
			op_q    <= RST_BYTE;
			start_q <= RST_WORD;
			count_q <= RST_WORD;
			ascii_q <= 1'b0;
			en32_q  <= 1'b0;
			gap_q   <= GAP_CNT;
			reply_q <= REPLY_CNT;
		end
		else if (i_wr && state_q == ST_IDLE)
		begin
			unique case (i_addr)
				OFS_CTRL:
				begin
					ascii_q <= i_wdata[CTRL_ASCII_BIT];
					en32_q  <= i_wdata[CTRL_EN32_BIT];
				end
				OFS_REQ_HEAD:
				begin
					slave_q <= i_wdata[7:0];
					op_q    <= i_wdata[15:8];
				end
				OFS_REQ_START: start_q <= i_wdata[15:0];
				OFS_REQ_COUNT: count_q <= i_wdata[15:0];
				OFS_GAP:       gap_q   <= i_wdata;
				OFS_REPLY:     reply_q <= i_wdata;
				default:       ;
			endcase
		end
	end

	// request sequencing and reply supervision
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state_q    <= ST_IDLE;
			wire_op_q  <= RST_BYTE;
			tx_idx_q   <= 9'd0;
			crc_q      <= CRC_INIT;
			tx_data_q  <= RST_BYTE;
			tx_valid_q <= 1'b0;
			timer_q    <= RST_DATA;
			done_q     <= 1'b0;
			tmo_q      <= 1'b0;
			crcerr_q   <= 1'b0;
			badop_q    <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					if (start_req)
					begin
						done_q   <= 1'b0;
						tmo_q    <= 1'b0;
						crcerr_q <= 1'b0;
						if (op_ok(op_q, i_wdata[CTRL_ASCII_BIT], i_wdata[CTRL_EN32_BIT]))
						begin
							badop_q    <= 1'b0;
							wire_op_q  <= op_q & ~OP_WIDE_MASK;
							tx_data_q  <= slave_q;
							tx_valid_q <= 1'b1;
							tx_idx_q   <= 9'd0;
							crc_q      <= CRC_INIT;
							state_q    <= ST_SEND;
						end
						else
						begin
							badop_q <= 1'b1;
						end
					end
				end
				ST_SEND:
				begin
					if (tx_fire)
					begin
						tx_idx_q  <= tx_nidx;
						tx_data_q <= tx_next;
						if (tx_idx_q < tx_len)
						begin
							crc_q <= tx_crc_n;
						end
						if (tx_nidx == tx_len + 9'd2)
						begin
							tx_valid_q <= 1'b0;
							timer_q    <= RST_DATA;
							crc_q      <= CRC_INIT;
							state_q    <= ST_WAIT;
						end
					end
				end
				ST_WAIT:
				begin
					if (i_rx_valid)
					begin
						crc_q   <= crc_upd(crc_q, i_rx_data);
						timer_q <= RST_DATA;
						state_q <= ST_RECV;
					end
					else if (timer_q + 32'd1 >= reply_q)
					begin
						tmo_q   <= 1'b1;
						state_q <= ST_IDLE;
					end
					else
					begin
						timer_q <= timer_q + 32'd1;
					end
				end
				ST_RECV:
				begin
					if (i_rx_valid)
					begin
						crc_q   <= crc_upd(crc_q, i_rx_data);
						timer_q <= RST_DATA;
					end
					else if (timer_q + 32'd1 >= gap_q)
					begin
						done_q   <= 1'b1;
						crcerr_q <= crc_q != RST_WORD;
						state_q  <= ST_IDLE;
					end
					else
					begin
						timer_q <= timer_q + 32'd1;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// reply header decode
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rx_idx_q <= 9'd0;
			nbytes_q <= RST_BYTE;
			exc_q    <= 1'b0;
			code_q   <= RST_BYTE;
		end
		else if (start_req)
		begin
			rx_idx_q <= 9'd0;
			nbytes_q <= RST_BYTE;
			exc_q    <= 1'b0;
			code_q   <= RST_BYTE;
		end
		else if ((state_q == ST_WAIT || state_q == ST_RECV) && i_rx_valid)
		begin
			if (rx_idx_q != 9'h1FF)
			begin
				rx_idx_q <= rx_idx_q + 9'd1;
			end
			if (rx_idx_q == 9'd1)
			begin
				exc_q <= (i_rx_data & OP_EXC_MASK) != RST_BYTE;
			end
			if (rx_idx_q == 9'd2)
			begin
				if (exc_q)
				begin
					code_q <= i_rx_data;
				end
				else
				begin
					nbytes_q <= i_rx_data;
				end
			end
		end
	end

	// payload placement into destination words
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			dcnt_q  <= RST_BYTE;
			pend_q  <= RST_BYTE;
			widx_q  <= '0;
			words_q <= 9'd0;
		end
		else if (start_req)
		begin
			dcnt_q  <= RST_BYTE;
			widx_q  <= '0;
			words_q <= 9'd0;
		end
		else if (is_data_byte)
		begin
			dcnt_q <= dcnt_q + 8'd1;
			if (!dcnt_q[0])
			begin
				pend_q <= i_rx_data;
			end
			if (dcnt_q[0] || last_data)
			begin
				widx_q  <= widx_q + 1'b1;
				words_q <= words_q + 9'd1;
			end
		end
	end

	always_comb
	begin
		mem_we    = is_data_byte && (dcnt_q[0] || last_data);
		mem_wdata = RST_WORD;
		if (is_bit_read(base_op))
		begin
			if (dcnt_q[0])
			begin
				mem_wdata = {i_rx_data, pend_q};
			end
			else
			begin
				mem_wdata = {PAD_BYTE, i_rx_data};
			end
		end
		else
		begin
			if (dcnt_q[0])
			begin
				mem_wdata = {pend_q, i_rx_data};
			end
			else
			begin
				mem_wdata = {i_rx_data, PAD_BYTE};
			end
		end
	end

	assign mem_raddr = i_addr[MEM_AW+1:2];

	mmrb_dest_mem #(
		.AW (MEM_AW),
		.DW (16)
	) u_dest (
		.i_clk   (i_clk),
		.i_we    (mem_we),
		.i_waddr (widx_q),
		.i_wdata (mem_wdata),
		.i_raddr (mem_raddr),
		.o_rdata (mem_rdata)
	);

	// register read port
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			reg_rdata_q <= RST_DATA;
			rd_dest_q   <= 1'b0;
		end
		else
		begin
			rd_dest_q   <= i_rd && i_addr[DEST_SEL_BIT];
			reg_rdata_q <= RST_DATA;
			if (i_rd && !i_addr[DEST_SEL_BIT])
			begin
				unique case (i_addr)
					OFS_CTRL:      reg_rdata_q <= {29'd0, en32_q, ascii_q, 1'b0};
					OFS_REQ_HEAD:  reg_rdata_q <= {16'd0, op_q, slave_q};
					OFS_REQ_START: reg_rdata_q <= {16'd0, start_q};
					OFS_REQ_COUNT: reg_rdata_q <= {16'd0, count_q};
					OFS_STATUS:    reg_rdata_q <= {7'd0, words_q, code_q, 2'd0, badop_q, crcerr_q,
						exc_q && done_q, tmo_q, done_q, o_busy};
					OFS_GAP:       reg_rdata_q <= gap_q;
					OFS_REPLY:     reg_rdata_q <= reply_q;
					default:       reg_rdata_q <= RST_DATA;
				endcase
			end
		end
	end

	assign o_rdata = rd_dest_q ? {16'd0, mem_rdata} : reg_rdata_q;
endmodule // mmrb_top

// ---- verification/mmrb_assertions.sv ----
`timescale 1ns/1ps
module mmrb_assertions
	import mmrb_pkg::*;
#(
	parameter int unsigned GAP_CNT   = 20,
	parameter int unsigned REPLY_CNT = 200
) (
	input wire logic        i_clk,
	input wire logic        i_resetn,
	input wire logic [10:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic [7:0]  o_tx_data,
	input wire logic        o_tx_valid,
	input wire logic        i_tx_ready,
	input wire logic [7:0]  i_rx_data,
	input wire logic        i_rx_valid,
	input wire logic        o_busy
);
	logic [3:0]  idx_q;
	logic [31:0] quiet_q;
	logic        seen_q;
	logic        acc;
	assign acc = o_tx_valid && i_tx_ready;
	// byte index, quiet cycles, reply seen
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			idx_q   <= 4'h0;
			quiet_q <= 32'h0;
			seen_q  <= 1'b0;
		end
		else
		begin
			idx_q   <= !o_busy ? 4'h0 : idx_q + 4'(acc);
			quiet_q <= (acc || i_rx_valid || !o_busy) ? 32'h0 : quiet_q + 32'h1;
			seen_q  <= o_busy && (seen_q || i_rx_valid);
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	a_start_ctrl: assert property ($rose(o_busy) |-> $past(i_wr) && $past(i_addr) == OFS_CTRL && o_tx_valid)
		else $error("busy rose without start");
	a_rdata_one: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data outside its cycle");
	a_tx_holds: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
		else $error("tx byte dropped");
	a_tx_busy: assert property (o_tx_valid |-> o_busy)
		else $error("tx while idle");
	a_op_narrow: assert property (o_tx_valid && idx_q == 4'h1 |-> !o_tx_data[6])
		else $error("wide bit sent");
	a_op_known: assert property (o_tx_valid && idx_q == 4'h1 |->
		o_tx_data inside {[8'h01:8'h08], 8'h0B, 8'h0C, 8'h0F, 8'h10})
		else $error("unsupported opcode sent");
	a_frame_len: assert property (acc |-> idx_q <= 4'h7)
		else $error("frame too long");
	a_crc_last: assert property (acc && idx_q == 4'h7 |=> !o_tx_valid)
		else $error("byte after crc");
	a_gap_end: assert property ($fell(o_busy) && seen_q |-> quiet_q + 2 >= GAP_CNT && quiet_q <= GAP_CNT + 2)
		else $error("reply end off gap");
	a_reply_limit: assert property ($fell(o_busy) && !seen_q |->
		quiet_q + 2 >= REPLY_CNT && quiet_q <= REPLY_CNT + 2)
		else $error("reply wait off limit");
	c_reply: cover property ($fell(o_busy) && seen_q);
	c_stall: cover property (o_tx_valid && !i_tx_ready);
	c_timeout: cover property ($fell(o_busy) && !seen_q);
endmodule // mmrb_assertions

// ---- verification/mmrb_slave_model.sv ----
`timescale 1ns/1ps
module mmrb_slave_model
	import mmrb_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	input  wire logic [7:0] i_tx_data,
	input  wire logic       i_tx_valid,
	output logic            o_tx_ready,
	output logic      [7:0] o_rx_data,
	output logic            o_rx_valid
);
	logic [7:0] got[$];
	logic       slow = 1'b0;
	initial
	begin
		o_rx_valid = 1'b0;
		o_rx_data  = 8'hA5;
	end
	// slow mode drops ready every other cycle
	always @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_tx_ready <= 1'b0;
		else
			o_tx_ready <= slow ? !o_tx_ready : 1'b1;
	end
	always @(posedge i_clk)
	begin
		if (i_tx_valid && o_tx_ready)
			got.push_back(i_tx_data);
	end
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = CRC_INIT;
		foreach (q[i])
		begin
			c = c ^ {8'h00, q[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		end
		return c;
	endfunction
	// reply, exception replies included, crc low then high
	task automatic reply(input logic [7:0] q[$]);
		logic [15:0] c;
		c = crc16(q);
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		foreach (q[i])
		begin
			@(posedge i_clk);
			o_rx_valid <= 1'b1;
			o_rx_data  <= q[i];
			@(posedge i_clk);
			o_rx_valid <= 1'b0;
			o_rx_data  <= ~q[i];
		end
	endtask
endmodule // mmrb_slave_model

// ---- verification/mmrb_top_tb_top.sv ----
`timescale 1ns/1ps
module mmrb_top_tb_top;
	import mmrb_pkg::*;
	localparam int unsigned GAP = 20;
	localparam int unsigned RPL = 200;
	logic        clk    = 1'b0;
	logic        resetn = 1'b0;
	logic [10:0] addr   = 11'h000;
	logic [31:0] wdata  = 32'h0;
	logic        bus_wr = 1'b0;
	logic        bus_rd = 1'b0;
	logic [31:0] rdata;
	logic [7:0]  tx_data, rx_data;
	logic        tx_valid, tx_ready, rx_valid, busy;
	int          failures = 0;
	int          n_compared = 0;
	always #25 clk = ~clk;
	mmrb_top #(.GAP_CNT(GAP), .REPLY_CNT(RPL), .MEM_AW(8)) mmrb_top_i (
		.i_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata), .i_wr(bus_wr), .i_rd(bus_rd),
		.o_rdata(rdata), .o_tx_data(tx_data), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready),
		.i_rx_data(rx_data), .i_rx_valid(rx_valid), .o_busy(busy));
	mmrb_slave_model mmrb_slave_model_i (.i_clk(clk), .i_resetn(resetn), .i_tx_data(tx_data),
		.i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_rx_data(rx_data), .o_rx_valid(rx_valid));
	task automatic wrap_up();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic reg_wr(input logic [10:0] a, input logic [31:0] d);
		@(posedge clk);
		addr   <= a;
		wdata  <= d;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [10:0] a, output logic [31:0] d);
		@(posedge clk);
		addr   <= a;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic status_is(input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] d;
		int          k;
		for (k = 0; k < 2000 && busy !== 1'b0; k++)
			@(posedge clk);
		if (k == 2000)
		begin
			failures++;
			wrap_up();
		end
		reg_rd(OFS_STATUS, d);
		check("status", exp, d & mask);
	endtask
	task automatic word_is(input logic [7:0] i, input logic [15:0] exp);
		logic [31:0] d;
		reg_rd({1'b1, i, 2'b00}, d);
		check("dest word", {16'h0000, exp}, d);
	endtask
	task automatic send(input logic [7:0] op, sent, input logic [15:0] st, cnt, input logic [1:0] mode);
		logic [7:0]  e[$];
		logic [15:0] c;
		int          k;
		e = {8'h11, sent};
		if (!(sent inside {OP_RD_EXC, OP_EV_CNT, OP_EV_LOG}))
			e = {e, st[15:8], st[7:0], cnt[15:8], cnt[7:0]};
		c = mmrb_slave_model_i.crc16(e);
		e = {e, c[7:0], c[15:8]};
		mmrb_slave_model_i.got.delete();
		reg_wr(OFS_REQ_HEAD, {16'h0000, op, 8'h11});
		reg_wr(OFS_REQ_START, {16'h0000, st});
		reg_wr(OFS_REQ_COUNT, {16'h0000, cnt});
		reg_wr(OFS_CTRL, {29'h0, mode, 1'b1});
		for (k = 0; k < 400 && mmrb_slave_model_i.got.size() < e.size(); k++)
			@(posedge clk);
		if (k == 400)
		begin
			failures++;
			wrap_up();
		end
		foreach (e[i])
			check("frame byte", {24'h0, e[i]}, {24'h0, mmrb_slave_model_i.got[i]});
	endtask
	task automatic t_map();
		logic [31:0] d;
		reg_rd(OFS_GAP, d);
		check("gap reset", GAP, d);
		reg_rd(11'h01C, d);
		check("unmapped read", 32'h0, d);
	endtask
	task automatic t_all_codes();
		logic [7:0] ops[12] = '{OP_RD_COILS, OP_RD_INPUTS, OP_RD_HOLD, OP_RD_INREG, OP_WR_COIL, OP_WR_REG,
			OP_RD_EXC, OP_LOOPBACK, OP_EV_CNT, OP_EV_LOG, OP_WR_COILS, OP_WR_REGS};
		foreach (ops[i])
		begin
			send(ops[i], ops[i], 16'hF0F0 + 16'(i), 16'h0001 + 16'(i), 2'b00);
			status_is(32'h0000003F, 32'h00000004);
		end
	endtask
	task automatic t_bits();
		mmrb_slave_model_i.slow <= 1'b1;
		send(OP_RD_COILS, OP_RD_COILS, 16'h0040, 16'h0014, 2'b00);
		mmrb_slave_model_i.reply('{8'h11, 8'h01, 8'h03, 8'hAA, 8'hBB, 8'hCC});
		status_is(32'h01FF003F, 32'h00020002);
		word_is(8'h00, 16'hBBAA);
		word_is(8'h01, 16'h00CC);
		mmrb_slave_model_i.slow <= 1'b0;
		send(OP_RD_INPUTS, OP_RD_INPUTS, 16'h0007, 16'h0005, 2'b00);
		mmrb_slave_model_i.reply('{8'h11, 8'h02, 8'h01, 8'h5A});
		status_is(32'h01FF003F, 32'h00010002);
		word_is(8'h00, 16'h005A);
	endtask
	task automatic t_regs();
		send(OP_RD_INREG, OP_RD_INREG, 16'h0100, 16'h0002, 2'b00);
		mmrb_slave_model_i.reply('{8'h11, 8'h04, 8'h04, 8'h12, 8'h34, 8'h56, 8'h78});
		status_is(32'h01FF003F, 32'h00020002);
		word_is(8'h00, 16'h1234);
		word_is(8'h01, 16'h5678);
		send(OP_RD_HOLD, OP_RD_HOLD, 16'h0200, 16'h0001, 2'b00);
		mmrb_slave_model_i.reply('{8'h11, 8'h03, 8'h02, 8'h9A, 8'hBC});
		status_is(32'h01FF003F, 32'h00010002);
		word_is(8'h00, 16'h9ABC);
		send(OP_RD_HOLD, OP_RD_HOLD, 16'h0300, 16'h0001, 2'b00);
		mmrb_slave_model_i.reply('{8'h11, 8'h83, 8'h02});
		status_is(32'h0000FF0B, 32'h0000020A);
	endtask
	task automatic t_wide();
		logic [7:0] wide[3] = '{8'h43, 8'h46, 8'h50};
		logic [7:0] base[3] = '{OP_RD_HOLD, OP_WR_REG, OP_WR_REGS};
		logic [7:0] bad[3]  = '{8'h09, 8'h43, 8'h83};
		foreach (wide[i])
		begin
			send(wide[i], base[i], 16'h0010, 16'h0002, 2'b11);
			status_is(32'h0000003F, 32'h00000004);
		end
		foreach (bad[i])
		begin
			mmrb_slave_model_i.got.delete();
			reg_wr(OFS_REQ_HEAD, {16'h0000, bad[i], 8'h11});
			reg_wr(OFS_CTRL, 32'h00000001);
			repeat (20) @(posedge clk);
			check("bytes sent", 32'h0, 32'(mmrb_slave_model_i.got.size()));
			status_is(32'h0000003F, 32'h00000020);
		end
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		t_map();
		t_all_codes();
		t_bits();
		t_regs();
		t_wide();
		wrap_up();
	end
endmodule // mmrb_top_tb_top
bind mmrb_top mmrb_assertions #(.GAP_CNT(GAP_CNT), .REPLY_CNT(REPLY_CNT)) mmrb_assertions_i (
	.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .o_tx_data(o_tx_data), .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready),
	.i_rx_data(i_rx_data), .i_rx_valid(i_rx_valid), .o_busy(o_busy));
